/* File: hw/pitc_pkg.sv */
// package: register map, field layout and types of the port ingress/tag control bank
package pitc_pkg;
  localparam int pitc_num_ports = 4;
  // byte addresses of the per-port control words; 0x40 stays reserved
  localparam logic [7:0] pitc_port1_cfg_addr = 8'h10;
  localparam logic [7:0] pitc_port2_cfg_addr = 8'h20;
  localparam logic [7:0] pitc_port3_cfg_addr = 8'h30;
  localparam logic [7:0] pitc_reserved_addr = 8'h40;
  localparam logic [7:0] pitc_port4_cfg_addr = 8'h50;
  // field positions
  localparam int pitc_storm_bit = 7;
  localparam int pitc_dscp_bit = 6;
  localparam int pitc_dot1p_bit = 5;
  localparam int pitc_defprio_lsb = 3;
  localparam int pitc_tag_ins_bit = 2;
  localparam int pitc_tag_rem_bit = 1;
  localparam int pitc_split_lo_bit = 0;
  localparam logic [7:0] pitc_cfg_reset = 8'h00;
  // queue-split codes {high bit from second register, low bit from this one}
  localparam logic [1:0] pitc_split_one = 2'b00;
  localparam logic [1:0] pitc_split_two = 2'b01;
  localparam logic [1:0] pitc_split_four = 2'b10;
  localparam logic [1:0] pitc_split_rsvd = 2'b11;

  typedef enum logic [1:0] {
    pitc_q_one,
    pitc_q_two,
    pitc_q_four,
    pitc_q_rsvd
  } pitc_qmode_type;

  // classification request from the frame parser, one per received frame
  typedef struct packed {
    logic valid;
    logic [1:0] port;
    logic dscp_hit;
    logic [1:0] dscp_prio;
    logic dot1p_hit;
    logic [1:0] dot1p_prio;
  } pitc_cls_req_type;

  // per-frame result, latched when the frame is classified
  typedef struct packed {
    logic valid;
    logic storm_protect;
    logic [1:0] prio;
  } pitc_cls_rsp_type;

  // egress edit request: output port, ingress port and reception tag state
  typedef struct packed {
    logic valid;
    logic [1:0] out_port;
    logic [1:0] in_port;
    logic rx_tagged;
  } pitc_egr_req_type;

  typedef struct packed {
    logic valid;
    logic insert_tag;
    logic strip_tag;
    logic [11:0] vlan_id;
  } pitc_egr_rsp_type;
endpackage : pitc_pkg

/* File: hw/pitc_port_ctrl.sv */
// port ingress priority and egress tag control register bank with ahb-lite slave
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - bit 7 of a port word turns on broadcast storm protection for frames received there.
// - bit 6 turns on priority classification by the DiffServ code point on that port.
// - bit 5 turns on priority classification by the 802.1p field on that port.
// - bits 4-3 give the default queue 0..3, used when no enabled classifier produces a result.
// - DiffServ, 802.1p and the default priority may all be enabled together on one port.
// - when both classifiers give a result they are ORed, and that replaces the default.
// - bit 2 makes frames leaving the port that arrived untagged get an 802.1Q tag.
// - with insertion on, frames that arrived tagged get no second tag.
// - an inserted tag carries the default VLAN id of the ingress port, not the output port.
// - bit 1 strips the tag from frames leaving the port that arrived tagged.
// - with removal on, frames that arrived untagged are not stripped; they leave unmodified unless bit 2 is also set.
// - the queue split is bit 0 here as low bit with a second register's bit 1 as high bit.
// - split code 10 means four queues, 01 two, 00 one, and 11 is reserved.
// - in single-queue mode the port ignores priority on transmit though frames stay classified.
// - the four port words share one layout at 0x10, 0x20, 0x30 and 0x50; 0x40 is reserved.
module pitc_port_ctrl
  import pitc_pkg::*;
#(
  parameter int ports = pitc_num_ports
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // queue-split high bits from the second per-port register, one per port
  input wire logic [3:0] split_hi,
  // per-port default vlan ids, 12 bits each, port 1 in the low bits
  input wire logic [47:0] ingress_default_vlan_id,
  // ingress classification
  input wire pitc_cls_req_type cls_req,
  output pitc_cls_rsp_type cls_rsp,
  // egress tag editing
  input wire pitc_egr_req_type egr_req,
  output pitc_egr_rsp_type egr_rsp,
  // per-port configuration to scheduler
  output logic [3:0] storm_en,
  output logic [7:0] queue_mode,
  output logic [3:0] prio_aware
);

  ////////////////////////////////////////////////////////////////////////////
  // ahb address phase capture
  logic wr_pend_q;
  logic [2:0] wr_idx_q;
  logic rd_pend_q;
  logic [2:0] rd_idx_q;
  logic [7:0] cfg_q [ports];

  wire addr_phase = hsel & hready & htrans[1];
  // map byte address to port index; 3'd7 marks unmapped or reserved
  wire [2:0] addr_idx = (haddr == pitc_port1_cfg_addr) ? 3'd0 :
                        (haddr == pitc_port2_cfg_addr) ? 3'd1 :
                        (haddr == pitc_port3_cfg_addr) ? 3'd2 :
                        (haddr == pitc_port4_cfg_addr) ? 3'd3 : 3'd7;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 3'd7;
      rd_pend_q <= 1'b0;
      rd_idx_q <= 3'd7;
    end else if (clk_en) begin
      wr_pend_q <= addr_phase & hwrite;
      rd_pend_q <= addr_phase & ~hwrite;
      if (addr_phase) begin
        wr_idx_q <= addr_idx;
        rd_idx_q <= addr_idx;
      end
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // register words and per-port decode
  logic [31:0] hrdata_q;
  wire [7:0] rd_word = (rd_idx_q < 3'd4) ? cfg_q[rd_idx_q[1:0]] : 8'h00;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (clk_en && addr_phase && !hwrite) begin
      hrdata_q <= {24'h00_0000, (addr_idx < 3'd4) ? cfg_q[addr_idx[1:0]] : 8'h00};
    end
  end
  // read data from the flop captured in address phase; rd_word kept for same-cycle writes
  assign hrdata = (rd_pend_q && wr_pend_q) ? {24'h00_0000, rd_word} : hrdata_q;

  genvar gp;
  generate
    for (gp = 0; gp < ports; gp++) begin : g_port
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          cfg_q[gp] <= pitc_cfg_reset;
        end else if (clk_en && wr_pend_q && wr_idx_q == 3'(gp)) begin
          cfg_q[gp] <= hwdata[7:0];
        end
      end
      assign storm_en[gp] = cfg_q[gp][pitc_storm_bit];
      // split code: high bit from the companion register, low bit local
      wire [1:0] split = {split_hi[gp], cfg_q[gp][pitc_split_lo_bit]};
      assign queue_mode[2*gp +: 2] = (split == pitc_split_four) ? 2'(pitc_q_four) :
                                     (split == pitc_split_two) ? 2'(pitc_q_two) :
                                     (split == pitc_split_one) ? 2'(pitc_q_one) :
                                     2'(pitc_q_rsvd);
      // single queue: scheduler treats all classes alike, classification still runs
      assign prio_aware[gp] = (split != pitc_split_one);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // ingress classification, one cycle, settings sampled at request time
  wire [7:0] in_cfg = cfg_q[cls_req.port];
  wire use_dscp = in_cfg[pitc_dscp_bit] & cls_req.dscp_hit;
  wire use_dot1p = in_cfg[pitc_dot1p_bit] & cls_req.dot1p_hit;
  wire [1:0] def_prio = in_cfg[pitc_defprio_lsb +: 2];
  // all three sources may be on; enabled hits are ORed and override default
  wire [1:0] or_prio = (use_dscp ? cls_req.dscp_prio : 2'b00) |
                       (use_dot1p ? cls_req.dot1p_prio : 2'b00);
  wire [1:0] cls_prio = (use_dscp | use_dot1p) ? or_prio : def_prio;
  pitc_cls_rsp_type cls_rsp_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cls_rsp_q <= '0;
    end else if (clk_en) begin
      // result latched per frame so later writes leave this frame alone
      cls_rsp_q.valid <= cls_req.valid;
      if (cls_req.valid) begin
        cls_rsp_q.storm_protect <= in_cfg[pitc_storm_bit];
        cls_rsp_q.prio <= cls_prio;
      end
    end
  end
  assign cls_rsp = cls_rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // egress tag decision, one cycle
  wire [7:0] out_cfg = cfg_q[egr_req.out_port];
  wire do_ins = out_cfg[pitc_tag_ins_bit] & ~egr_req.rx_tagged;
  wire do_strip = out_cfg[pitc_tag_rem_bit] & egr_req.rx_tagged;
  wire [11:0] ins_vid = ingress_default_vlan_id[12*egr_req.in_port +: 12];
  pitc_egr_rsp_type egr_rsp_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      egr_rsp_q <= '0;
    end else if (clk_en) begin
      egr_rsp_q.valid <= egr_req.valid;
      if (egr_req.valid) begin
        egr_rsp_q.insert_tag <= do_ins;
        egr_rsp_q.strip_tag <= do_strip;
        egr_rsp_q.vlan_id <= do_ins ? ins_vid : 12'h000;
      end
    end
  end
  assign egr_rsp = egr_rsp_q;

endmodule : pitc_port_ctrl
`default_nettype wire

/* File: dv/pitc_port_ctrl_asserts.sv */
// concurrent checks on the port ingress/tag control bank ports
`timescale 1ns/100ps
`default_nettype none
module pitc_port_ctrl_chk
  import pitc_pkg::*;
(
  // clock, reset, bus
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // frames and config
  input wire logic [3:0] split_hi,
  input wire logic [47:0] ingress_default_vlan_id,
  input wire pitc_cls_req_type cls_req,
  input wire pitc_cls_rsp_type cls_rsp,
  input wire pitc_egr_req_type egr_req,
  input wire pitc_egr_rsp_type egr_rsp,
  input wire logic [3:0] storm_en,
  input wire logic [7:0] queue_mode,
  input wire logic [3:0] prio_aware
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  a_rsvd_read: assert property (hsel && hready && htrans[1] && !hwrite && clk_en
    && haddr == 8'h40 |=> hrdata == 32'h0000_0000) else $error("reserved word nonzero");
  a_cls_answer: assert property (cls_req.valid && clk_en |=> cls_rsp.valid)
    else $error("no classify answer");
  a_cls_storm: assert property (cls_req.valid && clk_en
    |=> cls_rsp.storm_protect == $past(storm_en[cls_req.port])) else $error("storm flag");
  a_egr_answer: assert property (egr_req.valid && clk_en |=> egr_rsp.valid)
    else $error("no egress answer");
  a_no_dbl_tag: assert property (egr_req.valid && clk_en && egr_req.rx_tagged
    |=> !egr_rsp.insert_tag) else $error("second tag inserted");
  a_untag_kept: assert property (egr_req.valid && clk_en && !egr_req.rx_tagged
    |=> !egr_rsp.strip_tag) else $error("untagged frame stripped");
  a_vid_ingress: assert property ((egr_req.valid && clk_en) ##1 egr_rsp.insert_tag
    |-> egr_rsp.vlan_id == 12'($past(ingress_default_vlan_id >> (12 * egr_req.in_port))))
    else $error("wrong vlan id");
  a_split_high: assert property ({queue_mode[7], queue_mode[5], queue_mode[3],
    queue_mode[1]} == split_hi) else $error("split high bit");
  a_single_q: assert property (prio_aware == {|queue_mode[7:6], |queue_mode[5:4],
    |queue_mode[3:2], |queue_mode[1:0]}) else $error("priority awareness");
endmodule // pitc_port_ctrl_chk
bind pitc_port_ctrl pitc_port_ctrl_chk u_chk (.mclk, .rst, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .split_hi, .ingress_default_vlan_id,
  .cls_req, .cls_rsp, .egr_req, .egr_rsp, .storm_en, .queue_mode, .prio_aware);
`default_nettype wire

/* File: dv/test_pitc_port_ctrl.sv */
// self-checking bench for the port ingress/tag control bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_pitc_port_ctrl;
  import pitc_pkg::*;
  logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, clk_en = 1;
  logic [7:0] haddr = 0, queue_mode;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic [3:0] split_hi = 0, storm_en, prio_aware;
  logic [47:0] vid = 48'h0123_4567_89ab;
  pitc_cls_req_type cls_req = '0;
  pitc_cls_rsp_type cls_rsp;
  pitc_egr_req_type egr_req = '0;
  pitc_egr_rsp_type egr_rsp;
  int err_count = 0, total_checks = 0, seed = 72159, m[4] = '{0, 0, 0, 0}, i, p, t, o;
  logic [7:0] adr[4] = '{8'h10, 8'h20, 8'h30, 8'h50};
  pitc_port_ctrl dut (.mclk, .rst, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .split_hi,
    .ingress_default_vlan_id(vid), .cls_req, .cls_rsp, .egr_req, .egr_rsp, .storm_en,
    .queue_mode, .prio_aware);
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (!hreadyout);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (!hreadyout);
    rd = hrdata;
  endtask
  // one classify and one egress request per call, back to back with the next
  task automatic frame();
    p = $random(seed);
    cls_req <= {1'b1, p[7:0]};
    egr_req <= {1'b1, p[12:8]};
    @(posedge mclk);
    cls_req <= '0;
    egr_req <= '0;
    #1;
    i = p[7:6];
    t = 0;
    o = 0;
    if (m[i][6] && p[5]) begin t |= p[4:3]; o = 1; end
    if (m[i][5] && p[2]) begin t |= p[1:0]; o = 1; end
    if (o == 0) t = m[i][4:3];
    `CHK(cls_rsp, {1'b1, m[i][7], t[1:0]})
    o = p[12:11];
    t = m[o][2] && !p[8];
    `CHK(egr_rsp, {1'b1, t[0], m[o][1] & p[8], t[0] ? vid[12*p[10:9] +: 12] : 12'h000})
  endtask
  task automatic cfg();
    for (i = 0; i < 4; i++) begin
      `CHK(storm_en[i], m[i][7])
      `CHK(queue_mode[2*i +: 2], {split_hi[i], m[i][0]})
      `CHK(prio_aware[i], |{split_hi[i], m[i][0]})
      bus(0, adr[i], 32'h0000_0000);
      `CHK(rd, 32'(m[i]))
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 0;
    cfg();
    $display("reset test done");
    repeat (40) begin
      p = $random(seed);
      o = p[9:8];
      m[o] = p[7:0];
      bus(1, adr[o], p);
      split_hi <= p[13:10];
      repeat (4) frame();
      cfg();
    end
    $display("random test done");
    bus(1, 8'h40, 32'hffff_ffff);
    bus(0, 8'h40, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    cfg();
    $display("reserved test done");
    // a write while the enable is low must not land
    clk_en <= 0;
    bus(1, adr[0], {24'h00_0000, ~m[0][7:0]});
    clk_en <= 1;
    cfg();
    $display("enable test done");
    test_done();
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // whole run is about 820 cycles, so this only trips on a hang
  initial begin
    #100000;
    err_count++;
    test_done();
  end
endmodule // test_pitc_port_ctrl
`default_nettype wire
